// *** shared/eeprom_map.svh ***
// Purpose: constants of the two-wire eeprom sequencer
// Assumes: included by bare name from shared/
// Notes:   widths, layouts, codes and timing only; types live in eeprom_pkg
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH

`define DEV_TYPE_CODE     4'hA
`define TYPE_MSB          7
`define TYPE_LSB          4
`define RW_BIT            0
`define EXT_PINS          3
`define BASE_ADDR_W       8
`define ERASED_BYTE       8'hFF
`define PAGE_BYTES        16
`define PAGE_LSB_W        4
`define BYTE_LAST         3'h7
`define START_BITS        3'h2
`define MEM_BYTES_DEFAULT 256
`define WRITE_TIME_US     4000
`define CLOCK_MHZ         25

`endif

// *** shared/eeprom_pkg.sv ***
// Purpose: shared types of the two-wire eeprom sequencer
// Assumes: nothing
// Notes:   link state codes are one-hot
package eeprom_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [8:0]
  {
    s_idle      = 9'h001,
    s_devaddr   = 9'h002,
    s_ack_dev   = 9'h004,
    s_waddr     = 9'h008,
    s_ack_waddr = 9'h010,
    s_wdata     = 9'h020,
    s_ack_wdata = 9'h040,
    s_rdata     = 9'h080,
    s_rack      = 9'h100
  } link_state_t;

endpackage

// *** shared/mem_port_if.sv ***
// Purpose: link logic to array and write timer
// Assumes: page buffer and mask only change while the array is idle
// Notes:   commit_tgl is an event toggle from the stop detector
`timescale 1ns/1ps
`include "eeprom_map.svh"
interface mem_port_if #(parameter int ADDR_W = 8);
  logic                                 commit_tgl;
  logic [ADDR_W-`PAGE_LSB_W-1:0]        page;
  logic [`PAGE_BYTES-1:0][7:0]          page_data;
  logic [`PAGE_BYTES-1:0]               mask;
  logic [ADDR_W-1:0]                    rd_addr;
  logic [7:0]                           rd_data;
  logic                                 busy;

  modport ctrl
  (
    output commit_tgl, page, page_data, mask, rd_addr,
    input  rd_data, busy
  );
  modport array
  (
    input  commit_tgl, page, page_data, mask, rd_addr,
    output rd_data, busy
  );
endinterface

// *** core/eeprom_array.sv ***
// Purpose: memory array with page commit and internal write timer
// Assumes: page data is stable from stop until busy drops
// Notes:   runs on the system clock
`timescale 1ns/1ps
`include "eeprom_map.svh"
module eeprom_array #(
  parameter int MEM_BYTES    = `MEM_BYTES_DEFAULT,
  parameter int WRITE_CYCLES = `WRITE_TIME_US * `CLOCK_MHZ
) (
  // system
  input  wire logic clock,
  input  wire logic reset,
  // link side
  mem_port_if.array port
);
  localparam int ADDR_W = $clog2(MEM_BYTES);
  localparam int TMR_W  = $clog2(WRITE_CYCLES + 1);

  logic [7:0]        mem_r [MEM_BYTES];
  logic              commit_s1_r;
  logic              commit_s2_r;
  logic              commit_seen_r;
  logic              busy_r;
  logic [TMR_W-1:0]  timer_r;
  logic              commit_go;

  generate
    if (WRITE_CYCLES < 1)
    begin : g_bad_time
      $error("write cycle count must be at least one");
    end
  endgenerate

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      commit_s1_r   <= 1'b0;
      commit_s2_r   <= 1'b0;
      commit_seen_r <= 1'b0;
    end
    else
    begin
      commit_s1_r   <= port.commit_tgl;
      commit_s2_r   <= commit_s1_r;
      commit_seen_r <= commit_s2_r;
    end
  end

  // a second stop during the cycle cannot restart it
  assign commit_go = (commit_s2_r ^ commit_seen_r) && !busy_r;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      busy_r  <= 1'b0;
      timer_r <= '0;
    end
    else if (commit_go)
    begin
      busy_r  <= 1'b1;
      timer_r <= TMR_W'(WRITE_CYCLES - 1);
    end
    else if (busy_r)
    begin
      if (timer_r == '0)
        busy_r <= 1'b0;
      else
        timer_r <= timer_r - 1'b1;
    end
  end

  // all buffered bytes land in one cycle
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < MEM_BYTES; i++)
        mem_r[i] <= `ERASED_BYTE;
    end
    else if (commit_go)
    begin
      for (int i = 0; i < `PAGE_BYTES; i++)
        if (port.mask[i])
          mem_r[{port.page, `PAGE_LSB_W'(i)}] <= port.page_data[i];
    end
  end

  assign port.rd_data = mem_r[port.rd_addr];
  assign port.busy    = busy_r;
endmodule

// *** core/i2c_eeprom_access_sequencer.sv ***
// Purpose: slave side transaction sequencer of a two-wire serial eeprom
// Assumes: scl is the link clock; sda edges only mark start and stop
// Notes:   array reads cross quasi-statically, the array only changes while busy
`timescale 1ns/1ps
`include "eeprom_map.svh"
module i2c_eeprom_access_sequencer #(
  parameter int MEM_BYTES    = `MEM_BYTES_DEFAULT,
  parameter int WRITE_CYCLES = `WRITE_TIME_US * `CLOCK_MHZ
) (
  // system
  input  wire logic clock,
  input  wire logic reset,
  // two-wire bus
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  // straps and protection
  input  wire logic ext_addr_pin_0,
  input  wire logic ext_addr_pin_1,
  input  wire logic ext_addr_pin_2,
  input  wire logic write_protect,
  // status
  output logic      write_busy
);
  localparam int ADDR_W   = $clog2(MEM_BYTES);
  localparam int EXT_BITS = ADDR_W - `BASE_ADDR_W;

  eeprom_pkg::link_state_t          state_r;
  eeprom_pkg::byte_t                shift_r;
  eeprom_pkg::byte_t                tx_r;
  logic [2:0]                       cnt_r;
  logic [ADDR_W-1:0]                ptr_r;
  logic                             rw_r;
  logic                             wp_lat_r;
  logic                             wr_pend_r;
  logic [`PAGE_BYTES-1:0][7:0]      buf_r;
  logic [`PAGE_BYTES-1:0]           mask_r;
  logic                             sda_oe_r;
  logic                             sda_out_r;
  logic                             start_tgl_r;
  logic                             commit_tgl_r;
  logic                             start_s1_r;
  logic                             start_s2_r;
  logic                             start_seen_r;
  logic                             commit_s1_r;
  logic                             commit_s2_r;
  logic                             commit_seen_r;
  logic                             busy_s1_r;
  logic                             busy_s2_r;
  logic                             hold_r;
  logic                             wp_s1_r;
  logic                             wp_s2_r;
  logic [`EXT_PINS-1:0]             pins_s1_r;
  logic [`EXT_PINS-1:0]             pins_s2_r;
  logic                             start_evt;
  logic                             byte_done;
  logic                             busy_link;
  logic                             dev_hit;
  logic                             mst_ack;

  mem_port_if #(.ADDR_W(ADDR_W)) mem_bus ();

  generate
    if (MEM_BYTES != 256 && MEM_BYTES != 512 && MEM_BYTES != 1024 && MEM_BYTES != 2048)
    begin : g_bad_size
      $error("memory size must be 256, 512, 1024 or 2048 bytes");
    end
  endgenerate

  function automatic logic addr_match(input eeprom_pkg::byte_t b,
                                      input logic [`EXT_PINS-1:0] pins);
    logic ok;
    ok = (b[`TYPE_MSB:`TYPE_LSB] == `DEV_TYPE_CODE);
    for (int i = 0; i < `EXT_PINS; i++)
      if (i >= EXT_BITS && b[i+1] != pins[i])
        ok = 1'b0;
    return ok;
  endfunction

  // extension bits not matched against pins become the upper address
  function automatic logic [ADDR_W-1:0] load_hi(input eeprom_pkg::byte_t b,
                                                input logic [ADDR_W-1:0] p);
    logic [ADDR_W-1:0] r;
    r = p;
    for (int i = 0; i < EXT_BITS; i++)
      r[`BASE_ADDR_W+i] = b[i+1];
    return r;
  endfunction

  // start and stop: sda moving while scl is high
  always_ff @(negedge sda_in or posedge reset)
  begin
    if (reset)
      start_tgl_r <= 1'b0;
    else if (scl)
      start_tgl_r <= ~start_tgl_r;
  end

  // only a stop ends a write; a repeated start abandons it
  always_ff @(posedge sda_in or posedge reset)
  begin
    if (reset)
      commit_tgl_r <= 1'b0;
    else if (scl && wr_pend_r)
      commit_tgl_r <= ~commit_tgl_r;
  end

  // bits captured on the rising edge
  always_ff @(posedge scl or posedge reset)
  begin
    if (reset)
      shift_r <= '0;
    else
      shift_r <= {shift_r[6:0], sda_in};
  end

  // crossings into the link domain
  always_ff @(negedge scl or posedge reset)
  begin
    if (reset)
    begin
      start_s1_r    <= 1'b0;
      start_s2_r    <= 1'b0;
      start_seen_r  <= 1'b0;
      commit_s1_r   <= 1'b0;
      commit_s2_r   <= 1'b0;
      commit_seen_r <= 1'b0;
      busy_s1_r     <= 1'b0;
      busy_s2_r     <= 1'b0;
      wp_s1_r       <= 1'b0;
      wp_s2_r       <= 1'b0;
      pins_s1_r     <= '0;
      pins_s2_r     <= '0;
    end
    else
    begin
      start_s1_r    <= start_tgl_r;
      start_s2_r    <= start_s1_r;
      start_seen_r  <= start_s2_r;
      commit_s1_r   <= commit_tgl_r;
      commit_s2_r   <= commit_s1_r;
      commit_seen_r <= commit_s2_r;
      busy_s1_r     <= mem_bus.busy;
      busy_s2_r     <= busy_s1_r;
      wp_s1_r       <= write_protect;
      wp_s2_r       <= wp_s1_r;
      pins_s1_r     <= {ext_addr_pin_2, ext_addr_pin_1, ext_addr_pin_0};
      pins_s2_r     <= pins_s1_r;
    end
  end

  // bridges the gap until the system-side busy arrives here
  always_ff @(negedge scl or posedge reset)
  begin
    if (reset)
      hold_r <= 1'b0;
    else if (commit_s2_r ^ commit_seen_r)
      hold_r <= 1'b1;
    else if (busy_s2_r)
      hold_r <= 1'b0;
  end

  assign start_evt = start_s2_r ^ start_seen_r;
  assign byte_done = (cnt_r == `BYTE_LAST);
  assign busy_link = hold_r | busy_s2_r;
  assign dev_hit   = addr_match(shift_r, pins_s2_r) && !busy_link;
  assign mst_ack   = ~shift_r[0];

  // start seen two falling edges late, two address bits already in
  always_ff @(negedge scl or posedge reset)
  begin
    if (reset)
      cnt_r <= '0;
    else if (start_evt)
      cnt_r <= `START_BITS;
    else if (state_r == eeprom_pkg::s_devaddr || state_r == eeprom_pkg::s_waddr ||
             state_r == eeprom_pkg::s_wdata || state_r == eeprom_pkg::s_rdata)
      cnt_r <= byte_done ? 3'h0 : cnt_r + 3'h1;
    else
      cnt_r <= '0;
  end

  always_ff @(negedge scl or posedge reset)
  begin
    if (reset)
    begin
      state_r  <= eeprom_pkg::s_idle;
      rw_r     <= 1'b0;
      wp_lat_r <= 1'b0;
    end
    else if (start_evt)
      state_r <= eeprom_pkg::s_devaddr;
    else
    begin
      case (state_r)
        eeprom_pkg::s_idle:
          state_r <= eeprom_pkg::s_idle;
        eeprom_pkg::s_devaddr:
          if (byte_done)
          begin
            rw_r    <= shift_r[`RW_BIT];
            state_r <= dev_hit ? eeprom_pkg::s_ack_dev : eeprom_pkg::s_idle;
          end
        eeprom_pkg::s_ack_dev:
          state_r <= rw_r ? eeprom_pkg::s_rdata : eeprom_pkg::s_waddr;
        eeprom_pkg::s_waddr:
          if (byte_done)
            state_r <= eeprom_pkg::s_ack_waddr;
        eeprom_pkg::s_ack_waddr:
        begin
          wp_lat_r <= wp_s2_r;
          state_r  <= eeprom_pkg::s_wdata;
        end
        eeprom_pkg::s_wdata:
          if (byte_done)
            state_r <= wp_lat_r ? eeprom_pkg::s_idle : eeprom_pkg::s_ack_wdata;
        eeprom_pkg::s_ack_wdata:
          state_r <= eeprom_pkg::s_wdata;
        eeprom_pkg::s_rdata:
          if (byte_done)
            state_r <= eeprom_pkg::s_rack;
        eeprom_pkg::s_rack:
          state_r <= mst_ack ? eeprom_pkg::s_rdata : eeprom_pkg::s_idle;
        default:
          state_r <= eeprom_pkg::s_idle;
      endcase
    end
  end

  // address pointer
  always_ff @(negedge scl or posedge reset)
  begin
    if (reset)
      ptr_r <= '0;
    else
    begin
      case (state_r)
        eeprom_pkg::s_devaddr:
          if (byte_done && dev_hit)
            ptr_r <= load_hi(shift_r, ptr_r);
        eeprom_pkg::s_waddr:
          if (byte_done)
            ptr_r[`BASE_ADDR_W-1:0] <= shift_r;
        eeprom_pkg::s_ack_wdata:
          ptr_r[`PAGE_LSB_W-1:0] <= ptr_r[`PAGE_LSB_W-1:0] + 1'b1;
        eeprom_pkg::s_rdata:
          if (byte_done)
            ptr_r <= ptr_r + 1'b1;
        default:
          ptr_r <= ptr_r;
      endcase
    end
  end

  // open drain: a zero is driven low, a one released; changes on falling edge
  always_ff @(negedge scl or posedge reset)
  begin
    if (reset)
    begin
      sda_oe_r <= 1'b0;
      tx_r     <= '0;
    end
    else if (start_evt)
      sda_oe_r <= 1'b0;
    else
    begin
      case (state_r)
        eeprom_pkg::s_devaddr:
          sda_oe_r <= byte_done && dev_hit;
        eeprom_pkg::s_waddr:
          sda_oe_r <= byte_done;
        eeprom_pkg::s_wdata:
          sda_oe_r <= byte_done && !wp_lat_r;
        eeprom_pkg::s_ack_dev:
          if (rw_r)
          begin
            tx_r     <= mem_bus.rd_data;
            sda_oe_r <= ~mem_bus.rd_data[7];
          end
          else
            sda_oe_r <= 1'b0;
        eeprom_pkg::s_rdata:
          if (byte_done)
            sda_oe_r <= 1'b0;
          else
          begin
            tx_r     <= {tx_r[6:0], 1'b0};
            sda_oe_r <= ~tx_r[6];
          end
        eeprom_pkg::s_rack:
          if (mst_ack)
          begin
            tx_r     <= mem_bus.rd_data;
            sda_oe_r <= ~mem_bus.rd_data[7];
          end
          else
            sda_oe_r <= 1'b0;
        default:
          sda_oe_r <= 1'b0;
      endcase
    end
  end

  // page buffer; mask is only cleared while the array is idle
  always_ff @(negedge scl or posedge reset)
  begin
    if (reset)
    begin
      wr_pend_r <= 1'b0;
      mask_r    <= '0;
      buf_r     <= {`PAGE_BYTES{`ERASED_BYTE}};
    end
    else if (start_evt)
      wr_pend_r <= 1'b0;
    else if (state_r == eeprom_pkg::s_waddr && byte_done)
      mask_r <= '0;
    else if (state_r == eeprom_pkg::s_wdata && byte_done && !wp_lat_r)
    begin
      buf_r[ptr_r[`PAGE_LSB_W-1:0]]  <= shift_r;
      mask_r[ptr_r[`PAGE_LSB_W-1:0]] <= 1'b1;
      wr_pend_r                      <= 1'b1;
    end
  end

  // never drives a high level
  always_ff @(negedge scl or posedge reset)
  begin
    if (reset)
      sda_out_r <= 1'b0;
    else
      sda_out_r <= 1'b0;
  end

  assign mem_bus.commit_tgl = commit_tgl_r;
  assign mem_bus.page       = ptr_r[ADDR_W-1:`PAGE_LSB_W];
  assign mem_bus.page_data  = buf_r;
  assign mem_bus.mask       = mask_r;
  assign mem_bus.rd_addr    = ptr_r;

  eeprom_array #(
    .MEM_BYTES    (MEM_BYTES),
    .WRITE_CYCLES (WRITE_CYCLES)
  ) u_array (
    .clock (clock),
    .reset (reset),
    .port  (mem_bus.array)
  );

  assign sda_out    = sda_out_r;
  assign sda_oe     = sda_oe_r;
  assign write_busy = mem_bus.busy;
endmodule

// *** test/i2c_master_model.sv ***
// Purpose: behavioural two-wire bus master facing the eeprom
// Assumes: sda is the resolved open-drain line with a pull-up
// Notes:   scl stands still high between frames
`timescale 1ns/1ps
module i2c_master_model #(
  parameter int HALF = 6
) (
  // bus
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda
);
  initial
  begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end
  // data moves 1 ns after scl falls so no edge looks like start or stop
  task automatic bit_c(input logic v, output logic s);
    #1 sda_m = v;
    #(HALF - 1) scl = 1'b1;
    s = sda;
    #HALF scl = 1'b0;
  endtask
  task automatic start_c();
    #1 sda_m = 1'b1;
    #(HALF - 1) scl = 1'b1;
    #HALF sda_m = 1'b0;
    #HALF scl = 1'b0;
  endtask
  task automatic stop_c();
    #1 sda_m = 1'b0;
    #(HALF - 1) scl = 1'b1;
    #HALF sda_m = 1'b1;
    #HALF;
  endtask
  task automatic tx(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_c(b[i], s);
    bit_c(1'b1, s);
    ack = ~s;
  endtask
  task automatic rx(output logic [7:0] d, input logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_c(1'b1, d[i]);
    bit_c(~ack, s);
  endtask
endmodule

// *** test/i2c_eeprom_access_sequencer_properties.sv ***
// Purpose: concurrent checks on the sequencer ports
// Assumes: write protect is held high only over whole writes
// Notes:   stop is detected here independently of the design
`timescale 1ns/1ps
module eeprom_seq_checker #(
  parameter int WRITE_CYCLES = 50
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_protect,
  input wire logic write_busy
);
  logic       oe_rise_r;
  logic       stop_tgl_r;
  logic [2:0] sync_r;
  logic [3:0] since_r;
  logic [7:0] wp_cnt_r;
  int         busy_cnt_r;

  // level seen at the rise must still stand when scl falls
  always_ff @(posedge scl or posedge reset)
    oe_rise_r <= reset ? 1'b0 : sda_oe;
  always_ff @(posedge sda_in or posedge reset)
    stop_tgl_r <= reset ? 1'b0 : stop_tgl_r ^ scl;
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      sync_r     <= 3'h0;
      since_r    <= 4'hF;
      wp_cnt_r   <= 8'h00;
      busy_cnt_r <= 0;
    end
    else
    begin
      sync_r     <= {sync_r[1:0], stop_tgl_r};
      since_r    <= (sync_r[2] != sync_r[1]) ? 4'h0 : since_r + {3'h0, since_r != 4'hF};
      wp_cnt_r   <= write_protect ? wp_cnt_r + {7'h0, wp_cnt_r != 8'hFF} : 8'h00;
      busy_cnt_r <= write_busy ? busy_cnt_r + 1 : 0;
    end
  end

  property p_drive_low;
    @(posedge clock) disable iff (reset) sda_oe |-> !sda_out;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("sda not low");
  property p_fall_edge;
    @(negedge scl) disable iff (reset) sda_oe == oe_rise_r;
  endproperty
  a_fall_edge: assert property (p_fall_edge) else $error("sda moved");
  property p_busy_quiet;
    @(posedge scl) disable iff (reset) write_busy |-> !sda_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("busy drive");
  property p_after_stop;
    @(posedge clock) disable iff (reset) $rose(write_busy) |-> since_r <= 4'h6;
  endproperty
  a_after_stop: assert property (p_after_stop) else $error("no stop");
  property p_busy_hold;
    @(posedge clock) disable iff (reset) $rose(write_busy) |=> write_busy [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy short");
  property p_one_cycle;
    @(posedge clock) disable iff (reset) $fell(write_busy) && busy_cnt_r != 0
      |-> busy_cnt_r >= WRITE_CYCLES && busy_cnt_r <= WRITE_CYCLES + 1;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("busy length");
  property p_protect;
    @(posedge clock) disable iff (reset) $rose(write_busy) |-> wp_cnt_r != 8'hFF;
  endproperty
  a_protect: assert property (p_protect) else $error("wp write");
  property p_standby;
    @(posedge clock) disable iff (reset) $fell(reset) |-> !write_busy && !sda_oe;
  endproperty
  a_standby: assert property (p_standby) else $error("not standby");
endmodule
bind i2c_eeprom_access_sequencer eeprom_seq_checker #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
  .clock(clock), .reset(reset), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .write_protect(write_protect), .write_busy(write_busy));

// *** test/tb_i2c_eeprom_access_sequencer.sv ***
// Purpose: self-checking bench of the eeprom sequencer
// Assumes: 256-byte array, so all three extension bits match pins
// Notes:   short write time keeps polling loops brief
`timescale 1ns/1ps
`include "eeprom_map.svh"
module tb_i2c_eeprom_access_sequencer;
  logic        clock;
  logic        reset;
  logic        scl;
  logic        sda_m;
  logic        write_protect;
  logic [2:0]  pins;
  logic        sda_out;
  logic        sda_oe;
  logic        write_busy;
  wire         sda = sda_m & ~(sda_oe & ~sda_out);
  int          num_errors;
  int          check_count;
  logic [7:0]  mem [256];
  logic [7:0]  ptr;
  logic [7:0]  b;
  logic [31:0] lfsr_r;

  i2c_eeprom_access_sequencer #(.MEM_BYTES(256), .WRITE_CYCLES(50)) dut (
    .clock(clock), .reset(reset), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .ext_addr_pin_0(pins[0]), .ext_addr_pin_1(pins[1]),
    .ext_addr_pin_2(pins[2]), .write_protect(write_protect), .write_busy(write_busy));
  i2c_master_model m (.scl(scl), .sda_m(sda_m), .sda(sda));

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  function automatic logic [7:0] rnd();
    lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
    return lfsr_r[7:0];
  endfunction
  function automatic logic [7:0] dev(input logic rw);
    return {`DEV_TYPE_CODE, pins, rw};
  endfunction
  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input int n);
    logic ack;
    logic [7:0] d;
    @(negedge clock);
    m.start_c();
    m.tx(dev(1'b0), ack);
    chk1(ack, 1'b1);
    m.tx(a, ack);
    chk1(ack, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      d = rnd();
      m.tx(d, ack);
      chk1(ack, ~write_protect);
      if (!ack)
        break;
      mem[{a[7:4], a[3:0] + 4'(i)}] = d;
    end
    repeat (8) @(posedge clock);
    chk1(write_busy, 1'b0);
    m.stop_c();
  endtask
  task automatic poll(input logic nak_first);
    logic ack;
    for (int k = 0; k < 80; k++)
    begin
      m.start_c();
      m.tx(dev(1'b0), ack);
      m.stop_c();
      if (k == 0)
        chk1(ack, ~nak_first);
      if (ack)
        break;
    end
    chk1(ack, 1'b1);
    chk1(write_busy, 1'b0);
  endtask
  // a below zero means read on from the current pointer
  task automatic rd(input int a, input int n);
    logic ack;
    logic [7:0] d;
    @(negedge clock);
    if (a >= 0)
    begin
      m.start_c();
      m.tx(dev(1'b0), ack);
      m.tx(a[7:0], ack);
      chk1(ack, 1'b1);
      ptr = a[7:0];
    end
    m.start_c();
    m.tx(dev(1'b1), ack);
    chk1(ack, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      m.rx(d, i < n - 1);
      chk8(d, mem[ptr]);
      ptr = ptr + 8'h01;
    end
    m.stop_c();
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #800000;
    num_errors++;
    close_out();
  end

  initial
  begin
    logic ack;
    reset = 1'b1;
    write_protect = 1'b0;
    pins = 3'h0;
    num_errors = 0;
    check_count = 0;
    lfsr_r = 32'h000147C3;
    ptr = 8'h00;
    foreach (mem[i])
      mem[i] = `ERASED_BYTE;
    repeat (12) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    b = rnd();
    pins = b[2:0];
    @(negedge clock);
    rd(-1, 3);
    foreach (b[i])
    begin
      m.start_c();
      // seven address bits to spoil; the eighth pass spoils pin 0 again
      m.tx(dev(1'b0) ^ (8'h02 << (i % 7)), ack);
      m.stop_c();
      chk1(ack, 1'b0);
    end
    b = rnd();
    wr(b, 1);
    poll(1'b1);
    rd(b, 1);
    wr({b[7:4], 4'hE}, 18);
    poll(1'b1);
    rd({b[7:4], 4'h0}, 16);
    repeat (3)
    begin
      b = rnd();
      wr(b, 1 + int'(lfsr_r[11:8]));
      poll(1'b1);
      rd({b[7:4], 4'h0}, 16);
    end
    @(negedge clock);
    write_protect = 1'b1;
    wr(b, 2);
    poll(1'b0);
    @(negedge clock);
    write_protect = 1'b0;
    rd({b[7:4], 4'h0}, 16);
    rd(8'hFE, 4);
    rd(-1, 1);
    close_out();
  end
endmodule
